// [core/cocc_clock_output_config_control.sv]
// Configuration store, output enable and lock control of the clock generator.
// Assumes APB master on clk; select, enable, sleep and reference arrive as pins.
//
// Operation
// - four stored configurations, select pins pick one
// - configuration holds frequencies, spread, enables, type, cap
// - live select change applies, relocks if needed
// - low sleep input resets, forces outputs low
// - each enable pin gates its own output
// - outputs a/b low, or low/high pair, prelock
// - output c single-ended, low until locked
// - bypassed outputs carry copy of reference
// - outputs a/b single-ended pair or differential
// - undriven enable/select high, sleep low
// - spread settings modulate synthesized frequency
// - select code 00..11 picks first..fourth
// - differential pair follows enable line b only
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module cocc_clock_output_config_control #(
   parameter int LOCK_CNT = cocc_pkg::LOCK_CYCLES
) (
   input  wire logic                          clk,
   input  wire logic                          rst_n,
   input  wire logic [cocc_pkg::APB_AW-1:0]   paddr,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [31:0]                   pwdata,
   input  wire logic [3:0]                    pstrb,
   output logic [31:0]                        prdata,
   output logic                               pready,
   output logic                               pslverr,
   input  wire logic [1:0]                    sel_pin,
   input  wire logic [1:0]                    sel_pin_driven,
   input  wire logic                          enable_line_a,
   input  wire logic                          enable_line_b,
   input  wire logic                          enable_line_c,
   input  wire logic [2:0]                    enable_driven,
   input  wire logic                          sleep_n,
   input  wire logic                          sleep_n_driven,
   input  wire logic                          ref_input,
   output logic                               clock_out_a,
   output logic                               clock_out_b,
   output logic                               clock_out_c,
   output logic [cocc_pkg::MODE_CAP_W-1:0]    cap_code,
   output logic                               pll_locked
);
   import cocc_pkg::*;

   localparam int SYNC_W = 13;

   function automatic logic resolve(input logic val, input logic drv, input logic pull);
      resolve = drv ? val : pull;
   endfunction : resolve

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [SYNC_W-1:0] sync1_r;
   logic [SYNC_W-1:0] sync2_r;
   logic [SYNC_W-1:0] pins_raw;

   assign pins_raw = {ref_input, sleep_n_driven, sleep_n, enable_driven,
                      enable_line_c, enable_line_b, enable_line_a, sel_pin_driven, sel_pin};

   always_ff @(posedge clk) begin
      sync1_r <= pins_raw;
      sync2_r <= sync1_r;
   end

   logic [1:0] sel_res;
   logic [2:0] en_res;
   logic       sleep_res_n;
   logic       ref_s;

   always_comb begin
      sel_res[0]  = resolve(sync2_r[0], sync2_r[2], 1'b1);
      sel_res[1]  = resolve(sync2_r[1], sync2_r[3], 1'b1);
      for (int i = 0; i < 3; i++) begin
         en_res[i] = resolve(sync2_r[4+i], sync2_r[7+i], 1'b1);
      end
      sleep_res_n = resolve(sync2_r[10], sync2_r[11], 1'b0);
      ref_s       = sync2_r[12];
   end

   // Asynchronous clear of the output stage, straight from the pins
   logic sleep_async_n;
   assign sleep_async_n = sleep_n_driven & sleep_n;

   ////////////////////////////////////////////////////////////////////////////
   // APB register file
   logic [31:0] div_r  [NUM_CFG];
   logic [31:0] div_nxt[NUM_CFG];
   logic [31:0] mode_r [NUM_CFG];
   logic [31:0] mode_nxt[NUM_CFG];
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic        cfg_hit;
   logic        stat_hit;
   logic [1:0]  widx;
   logic [31:0] status_w;

   function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] be);
      strb_merge = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            strb_merge[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
   endfunction : strb_merge

   assign cfg_hit  = (paddr[CFG_REGION_H:CFG_REGION_L] == '0) && (paddr[1:0] == 2'h0);
   assign stat_hit = (paddr == OFS_STATUS);
   assign widx     = paddr[CFG_IDX_H:CFG_IDX_L];
   assign pready   = psel & penable;
   assign pslverr  = psel & penable & !(cfg_hit || (stat_hit && !pwrite));
   assign prdata   = rdata_r;

   always_comb begin
      for (int n = 0; n < NUM_CFG; n++) begin
         div_nxt[n]  = div_r[n];
         mode_nxt[n] = mode_r[n];
      end
      rdata_nxt = rdata_r;
      if (psel && !penable && !pwrite) begin
         rdata_nxt = 32'h0000_0000;
         if (cfg_hit) begin
            rdata_nxt = paddr[CFG_WORD_BIT] ? mode_r[widx] : div_r[widx];
         end else if (stat_hit) begin
            rdata_nxt = status_w;
         end
      end
      if (psel && penable && pwrite && cfg_hit) begin
         if (paddr[CFG_WORD_BIT]) begin
            mode_nxt[widx] = strb_merge(mode_r[widx], pwdata, pstrb);
         end else begin
            div_nxt[widx] = strb_merge(div_r[widx], pwdata, pstrb);
         end
      end
      if (!rst_n) begin
         for (int n = 0; n < NUM_CFG; n++) begin
            div_nxt[n]  = DIV_RESET;
            mode_nxt[n] = MODE_RESET;
         end
         rdata_nxt = 32'h0000_0000;
      end
   end

   always_ff @(posedge clk) begin
      for (int n = 0; n < NUM_CFG; n++) begin
         div_r[n]  <= div_nxt[n];
         mode_r[n] <= mode_nxt[n];
      end
      rdata_r <= rdata_nxt;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Active configuration and lock sequencing
   logic [1:0]    act_r;
   logic [1:0]    act_nxt;
   logic [31:0]   act_div;
   logic [31:0]   act_mode;
   logic [DIV_W*3+MODE_PLL_MSB-MODE_PLL_LSB:0] pll_sig;
   logic [DIV_W*3+MODE_PLL_MSB-MODE_PLL_LSB:0] sig_r;
   logic [DIV_W*3+MODE_PLL_MSB-MODE_PLL_LSB:0] sig_nxt;
   cocc_pll_st_t  st_r;
   cocc_pll_st_t  st_nxt;
   logic [31:0]   lcnt_r;
   logic [31:0]   lcnt_nxt;

   assign act_div  = div_r[act_r];
   assign act_mode = mode_r[act_r];
   assign pll_sig  = {act_div[DIV_W*3-1:0], act_mode[MODE_PLL_MSB:MODE_PLL_LSB]};

   always_comb begin
      act_nxt  = sel_res;
      sig_nxt  = pll_sig;
      st_nxt   = st_r;
      lcnt_nxt = lcnt_r;
      case (st_r)
         PLL_SLEEP: begin
            lcnt_nxt = 32'h0000_0000;
            if (sleep_res_n) begin
               st_nxt = PLL_ACQ;
            end
         end
         PLL_ACQ: begin
            lcnt_nxt = lcnt_r + 32'h0000_0001;
            if (lcnt_r >= 32'(LOCK_CNT - 1)) begin
               st_nxt = PLL_LOCKED;
            end
         end
         PLL_LOCKED: begin
            if (pll_sig != sig_r) begin
               st_nxt   = PLL_ACQ;
               lcnt_nxt = 32'h0000_0000;
            end
         end
         default: begin
            st_nxt = PLL_SLEEP;
         end
      endcase
      if (st_r == PLL_ACQ && pll_sig != sig_r) begin
         lcnt_nxt = 32'h0000_0000;
         st_nxt   = PLL_ACQ;
      end
      if (!rst_n || !sleep_res_n) begin
         st_nxt   = PLL_SLEEP;
         lcnt_nxt = 32'h0000_0000;
         act_nxt  = 2'h0;
      end
   end

   always_ff @(posedge clk) begin
      act_r  <= act_nxt;
      sig_r  <= sig_nxt;
      st_r   <= st_nxt;
      lcnt_r <= lcnt_nxt;
   end

   assign pll_locked = (st_r == PLL_LOCKED);
   assign cap_code   = act_mode[MODE_CAP_LSB +: MODE_CAP_W];

   assign status_w = {23'h000000, sel_res, sleep_res_n, en_res, pll_locked, act_r};

   ////////////////////////////////////////////////////////////////////////////
   // Synthesized clocks
   logic signed [SS_OFS_W-1:0] ss_ofs;
   logic [2:0]                 syn;

   cocc_spread u_spread (
      .clk       (clk),
      .rst_n     (rst_n),
      .run       (pll_locked),
      .ss_type   (act_mode[MODE_SST_LSB +: 2]),
      .deviation (act_mode[MODE_DEV_LSB +: SS_DEV_W]),
      .rate      (act_mode[MODE_RATE_LSB +: SS_RATE_W]),
      .offset    (ss_ofs)
   );

   for (genvar g = 0; g < 3; g++) begin : g_div
      cocc_divider #(.DW(DIV_W), .OW(SS_OFS_W)) u_div (
         .clk         (clk),
         .rst_n       (rst_n),
         .run         (pll_locked),
         .half_period (act_div[g*DIV_W +: DIV_W]),
         .offset      (ss_ofs),
         .clk_q       (syn[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output selection, glitch-free gating and output stage
   logic       diff;
   logic [2:0] src;
   logic [2:0] want;
   logic [2:0] gate_r;
   logic [2:0] gate_nxt;
   logic [2:0] out_nxt;
   logic [2:0] out_r;

   assign diff = act_mode[MODE_DIFF_BIT];

   always_comb begin
      for (int i = 0; i < 3; i++) begin
         // Bypass copies the reference; otherwise the divider after lock
         src[i]  = act_mode[MODE_BYP_LSB+i] ? ref_s : (pll_locked & syn[i]);
         want[i] = en_res[i] & act_mode[MODE_EN_LSB+i];
      end
      if (diff) begin
         src[1]  = src[0];
         want[0] = en_res[1] & act_mode[MODE_EN_LSB+1];
         want[1] = want[0];
      end
      gate_nxt = gate_r;
      for (int i = 0; i < 3; i++) begin
         if (!src[i]) begin
            gate_nxt[i] = want[i];
         end
      end
      out_nxt[0] = gate_r[0] & src[0];
      out_nxt[2] = gate_r[2] & src[2];
      out_nxt[1] = diff ? !(gate_r[0] & src[0]) : (gate_r[1] & src[1]);
      if (!rst_n || !sleep_res_n) begin
         gate_nxt = 3'h0;
         out_nxt  = 3'h0;
      end
   end

   always_ff @(posedge clk) begin
      gate_r <= gate_nxt;
   end

   always_ff @(posedge clk or negedge sleep_async_n) begin
      if (!sleep_async_n) begin
         out_r <= 3'h0;
      end else begin
         out_r <= out_nxt;
      end
   end

   assign clock_out_a = out_r[0];
   assign clock_out_b = out_r[1];
   assign clock_out_c = out_r[2];

endmodule : cocc_clock_output_config_control
`default_nettype wire

// [core/cocc_divider.sv]
// Output divider: square wave with a programmable half period.
// Assumes the spread offset comes from the same clock domain.
`timescale 1ns/100ps
`default_nettype none
module cocc_divider #(
   parameter int DW = 8,
   parameter int OW = 6
) (
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire logic                 run,
   input  wire logic [DW-1:0]        half_period,
   input  wire logic signed [OW-1:0] offset,
   output logic                      clk_q
);
   import cocc_pkg::*;

   logic [DW:0]          cnt_r;
   logic [DW:0]          cnt_nxt;
   logic                 q_r;
   logic                 q_nxt;
   logic signed [DW+1:0] span;

   always_comb begin
      span    = $signed({2'b00, half_period}) + (DW+2)'(offset);
      if (span < $signed((DW+2)'(1))) begin
         span = (DW+2)'(1);
      end
      cnt_nxt = cnt_r;
      q_nxt   = q_r;
      if (!rst_n || !run) begin
         cnt_nxt = '0;
         q_nxt   = 1'b0;
      end else if ({1'b0, cnt_r} >= (DW+2)'(span - (DW+2)'(1))) begin
         cnt_nxt = '0;
         q_nxt   = !q_r;
      end else begin
         cnt_nxt = cnt_r + (DW+1)'(1);
      end
   end

   always_ff @(posedge clk) begin
      cnt_r <= cnt_nxt;
      q_r   <= q_nxt;
   end

   assign clk_q = q_r;

endmodule : cocc_divider
`default_nettype wire

// [core/cocc_pkg.sv]
// Shared constants for the clock output configuration control block.
// Assumes a 20 MHz system clock and an APB slave port with 32-bit data.
package cocc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Clock and timing
   localparam int CLK_HZ       = 20_000_000;
   localparam int CLK_MHZ      = CLK_HZ / 1_000_000;
   localparam int LOCK_TIME_NS = 100_000;
   localparam int LOCK_CYCLES  = (LOCK_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int RATE_UNIT    = 16;

   ////////////////////////////////////////////////////////////////////////////
   // Register map
   localparam int             NUM_CFG      = 4;
   localparam int             APB_AW       = 8;
   localparam logic [7:0]     OFS_STATUS   = 8'h20;
   localparam int             CFG_REGION_H = 7;
   localparam int             CFG_REGION_L = 5;
   localparam int             CFG_IDX_H    = 4;
   localparam int             CFG_IDX_L    = 3;
   localparam int             CFG_WORD_BIT = 2;

   // Divider word: half periods of outputs a, b, c
   localparam int DIV_W       = 8;
   localparam int DIV_A_LSB   = 0;
   localparam int DIV_B_LSB   = 8;
   localparam int DIV_C_LSB   = 16;

   // Mode word
   localparam int MODE_EN_LSB   = 0;
   localparam int MODE_DIFF_BIT = 3;
   localparam int MODE_BYP_LSB  = 4;
   localparam int MODE_SST_LSB  = 7;
   localparam int MODE_DEV_LSB  = 9;
   localparam int MODE_RATE_LSB = 13;
   localparam int MODE_CAP_LSB  = 17;
   localparam int MODE_CAP_W    = 9;
   localparam int MODE_PLL_LSB  = 7;
   localparam int MODE_PLL_MSB  = 25;
   localparam int SS_DEV_W      = 4;
   localparam int SS_RATE_W     = 4;
   localparam int SS_OFS_W      = 6;

   localparam logic [31:0] DIV_RESET  = 32'h0004_0404;
   localparam logic [31:0] MODE_RESET = 32'h0000_0007;

   // Status word
   localparam int ST_IDX_LSB   = 0;
   localparam int ST_LOCK_BIT  = 2;
   localparam int ST_EN_LSB    = 3;
   localparam int ST_SLEEP_BIT = 6;
   localparam int ST_SEL_LSB   = 7;

   ////////////////////////////////////////////////////////////////////////////
   // Enumerations
   localparam logic [1:0] SS_OFF    = 2'h0;
   localparam logic [1:0] SS_DOWN   = 2'h1;
   localparam logic [1:0] SS_CENTER = 2'h2;

   typedef enum logic [2:0] {
      PLL_SLEEP  = 3'b001,
      PLL_ACQ    = 3'b010,
      PLL_LOCKED = 3'b100
   } cocc_pll_st_t;

endpackage : cocc_pkg

// [core/cocc_spread.sv]
// Triangle spread modulator giving a signed half-period offset.
// Assumes settings are stable while run is high, else restart.
`timescale 1ns/100ps
`default_nettype none
module cocc_spread #(
   parameter int RATE_STEP = cocc_pkg::RATE_UNIT
) (
   input  wire logic                                   clk,
   input  wire logic                                   rst_n,
   input  wire logic                                   run,
   input  wire logic [1:0]                             ss_type,
   input  wire logic [cocc_pkg::SS_DEV_W-1:0]          deviation,
   input  wire logic [cocc_pkg::SS_RATE_W-1:0]         rate,
   output logic signed [cocc_pkg::SS_OFS_W-1:0]        offset
);
   import cocc_pkg::*;

   logic [11:0]         pre_r;
   logic [11:0]         pre_nxt;
   logic [SS_DEV_W-1:0] ph_r;
   logic [SS_DEV_W-1:0] ph_nxt;
   logic                up_r;
   logic                up_nxt;
   logic signed [SS_OFS_W-1:0] ofs_r;
   logic signed [SS_OFS_W-1:0] ofs_nxt;
   logic [11:0]         pre_end;

   always_comb begin
      pre_end = 12'((32'(rate) + 1) * RATE_STEP - 1);
      pre_nxt = pre_r + 12'h001;
      ph_nxt  = ph_r;
      up_nxt  = up_r;
      if (pre_r >= pre_end) begin
         pre_nxt = 12'h000;
         if (up_r) begin
            if (ph_r >= deviation) begin
               up_nxt = 1'b0;
            end else begin
               ph_nxt = ph_r + SS_DEV_W'(1);
            end
         end else begin
            if (ph_r == '0) begin
               up_nxt = 1'b1;
            end else begin
               ph_nxt = ph_r - SS_DEV_W'(1);
            end
         end
      end
      // Down spread stretches periods only; center straddles nominal
      case (ss_type)
         SS_DOWN:   ofs_nxt = SS_OFS_W'(ph_r);
         SS_CENTER: ofs_nxt = SS_OFS_W'(ph_r) - SS_OFS_W'(deviation >> 1);
         default:   ofs_nxt = '0;
      endcase
      if (!rst_n || !run) begin
         pre_nxt = 12'h000;
         ph_nxt  = '0;
         up_nxt  = 1'b1;
         ofs_nxt = '0;
      end
   end

   always_ff @(posedge clk) begin
      pre_r <= pre_nxt;
      ph_r  <= ph_nxt;
      up_r  <= up_nxt;
      ofs_r <= ofs_nxt;
   end

   assign offset = ofs_r;

endmodule : cocc_spread
`default_nettype wire

// [test/cocc_chk.sv]
// Port checker for the clock output configuration control block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module cocc_chk
   import cocc_pkg::*;
#(
   parameter int LOCK_CNT = 20
) (
   input wire logic                        clk,
   input wire logic                        rst_n,
   input wire logic [cocc_pkg::APB_AW-1:0] paddr,
   input wire logic                        psel,
   input wire logic                        penable,
   input wire logic                        pwrite,
   input wire logic [31:0]                 pwdata,
   input wire logic                        pready,
   input wire logic                        pslverr,
   input wire logic                        enable_line_c,
   input wire logic [2:0]                  enable_driven,
   input wire logic                        sleep_n,
   input wire logic                        sleep_n_driven,
   input wire logic                        clock_out_a,
   input wire logic                        clock_out_b,
   input wire logic                        clock_out_c,
   input wire logic                        pll_locked
);
   logic        byp_r, byp_nxt;
   logic [15:0] low_r, low_nxt;
   ////////////////////////////////////////////////////////////////////////////
   // Bypass ever written, cycles spent unlocked
   always_comb begin
      byp_nxt = byp_r | (psel & penable & pwrite & paddr[2] & !paddr[7:5] & (|pwdata[6:4]));
      low_nxt = pll_locked ? 16'h0000 : low_r + {15'h0000, ~&low_r};
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         byp_r <= 1'b0;
         low_r <= 16'h0000;
      end else begin
         byp_r <= byp_nxt;
         low_r <= low_nxt;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_asleep;
      (!(sleep_n & sleep_n_driven))[*5];
   endsequence
   sequence s_c_off;
      (enable_driven[2] & !enable_line_c)[*5];
   endsequence
   property p_prelock(logic o);
      !pll_locked && !$past(pll_locked) && !$past(pll_locked, 2) && !byp_r |-> !o;
   endproperty
   a_sleep_outs_low: assert property (!(sleep_n & sleep_n_driven) |-> !clock_out_a && !clock_out_b && !clock_out_c)
      else $error("output high while asleep");
   a_undriven_quiet: assert property (!sleep_n_driven |-> !(clock_out_a | clock_out_b | clock_out_c))
      else $error("output high with sleep undriven");
   a_asleep_unlock: assert property (s_asleep |-> !pll_locked)
      else $error("lock while asleep");
   a_lock_wait: assert property ($rose(pll_locked) |-> int'(low_r) >= LOCK_CNT)
      else $error("lock came too early");
   a_prelock_a: assert property (p_prelock(clock_out_a))
      else $error("output a high before lock");
   a_prelock_c: assert property (p_prelock(clock_out_c))
      else $error("output c high before lock");
   a_c_stays_off: assert property (s_c_off ##0 !clock_out_c |=> !clock_out_c)
      else $error("disabled output c rose");
   a_apb_ready: assert property (psel && penable |-> pready)
      else $error("no ready in access phase");
   a_bad_addr: assert property (psel && penable && (paddr > 8'h20) |-> pslverr)
      else $error("no error on unmapped address");
endmodule : cocc_chk

bind cocc_clock_output_config_control cocc_chk #(.LOCK_CNT(LOCK_CNT)) cocc_chk_inst (
   .clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
   .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .enable_line_c(enable_line_c),
   .enable_driven(enable_driven), .sleep_n(sleep_n), .sleep_n_driven(sleep_n_driven),
   .clock_out_a(clock_out_a), .clock_out_b(clock_out_b), .clock_out_c(clock_out_c),
   .pll_locked(pll_locked));
`default_nettype wire

// [test/cocc_clock_output_config_control_bench.sv]
// Self-checking bench of the clock output configuration control block.
// Assumes the pin model and the bound checker are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
module cocc_clock_output_config_control_bench;
   import cocc_pkg::*;
   localparam int LOCK = 20;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [1:0] sel_pin, sel_drv;
   logic ea, eb, ec, sn, sn_drv, refc, ca, cb, cc, locked;
   logic [2:0] en_drv;
   logic [8:0] cap;
   int failures = 0, tests_run = 0, hi, n;

   cocc_clock_output_config_control #(.LOCK_CNT(LOCK)) cocc_clock_output_config_control_inst (
      .clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sel_pin(sel_pin), .sel_pin_driven(sel_drv), .enable_line_a(ea), .enable_line_b(eb),
      .enable_line_c(ec), .enable_driven(en_drv), .sleep_n(sn), .sleep_n_driven(sn_drv),
      .ref_input(refc), .clock_out_a(ca), .clock_out_b(cb), .clock_out_c(cc), .cap_code(cap),
      .pll_locked(locked));
   cocc_pin_model cocc_pin_model_inst (
      .clk(clk), .sel_pin(sel_pin), .sel_pin_driven(sel_drv), .enable_line_a(ea), .enable_line_b(eb),
      .enable_line_c(ec), .enable_driven(en_drv), .sleep_n(sn), .sleep_n_driven(sn_drv), .ref_input(refc));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic e;
      apb(1'b1, a, d, e);
      chk(32'(e), 32'h0);
   endtask : wr
   task automatic wait_lock(output int c);
      for (c = 0; locked !== 1'b1 && c < 400; c++) @(posedge clk);
   endtask : wait_lock
   function automatic logic outv(input int i);
      return i == 0 ? ca : i == 1 ? cb : cc;
   endfunction : outv
   // Next high pulse width in cycles
   task automatic measure(input int i, output int h);
      while (outv(i) !== 1'b0) @(posedge clk);
      while (outv(i) !== 1'b1) @(posedge clk);
      for (h = 0; outv(i) === 1'b1; h++) @(posedge clk);
   endtask : measure
   task automatic low_for(input int i, input int cyc);
      logic seen = 1'b0;
      repeat (cyc) begin
         @(posedge clk);
         seen |= outv(i);
      end
      chk(32'(seen), 32'h0);
   endtask : low_for
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      logic e;
      apb(1'b0, 8'h00, 32'h0, e);
      chk(r, 32'h0004_0404);
      apb(1'b0, 8'h1C, 32'h0, e);
      chk(r, 32'h0000_0007);
      apb(1'b0, 8'h24, 32'h0, e);
      chk(32'(e), 32'h1);
      apb(1'b1, 8'h20, 32'h0, e);
      chk(32'(e), 32'h1);
   endtask : t_regs
   task automatic t_undriven;
      logic e;
      repeat (30) @(posedge clk);
      chk({28'h0, ca, cb, cc, locked}, 32'h0);
      apb(1'b0, 8'h20, 32'h0, e);
      chk(r, 32'h0000_01B8);
   endtask : t_undriven
   task automatic t_select;
      logic e;
      for (int i = 0; i < 4; i++) wr(8'(8 * i), 32'h302 | (i + 2) << 16);
      cocc_pin_model_inst.drive_sleep(1'b1, 1'b1);
      wait_lock(n);
      chk(32'(n >= LOCK && n <= LOCK + 8), 32'h1);
      for (int i = 0; i < 4; i++) begin
         cocc_pin_model_inst.drive_sel(2'(i), 2'h3);
         repeat (8) @(posedge clk);
         wait_lock(n);
         apb(1'b0, 8'h20, 32'h0, e);
         chk(r & 32'h7, 32'h4 | i);
         measure(2, hi);
         chk(hi, i + 2);
         measure(0, hi);
         chk(hi, 2);
      end
   endtask : t_select
   task automatic t_enable;
      cocc_pin_model_inst.drive_en(3'h3, 3'h7);
      repeat (12) @(posedge clk);
      low_for(2, 30);
      measure(0, hi);
      chk(hi, 2);
      cocc_pin_model_inst.drive_en(3'h7, 3'h7);
      measure(2, hi);
      chk(hi, 5);
   endtask : t_enable
   task automatic t_diff;
      wr(8'h1C, 32'h0000_000F);
      repeat (6) @(posedge clk);
      repeat (20) begin
         @(posedge clk);
         chk(32'(cb), {31'h0, ~ca});
      end
      cocc_pin_model_inst.drive_en(3'h6, 3'h7);
      measure(0, hi);
      chk(hi, 2);
      cocc_pin_model_inst.drive_en(3'h5, 3'h7);
      repeat (12) @(posedge clk);
      low_for(0, 20);
      cocc_pin_model_inst.drive_en(3'h7, 3'h7);
      wr(8'h1C, 32'h0000_0007);
   endtask : t_diff
   task automatic t_bypass;
      wr(8'h1C, 32'h02AA_0047);
      repeat (6) @(posedge clk);
      chk({23'h0, cap}, 32'h155);
      measure(2, hi);
      chk(hi, 3);
      wait_lock(n);
      measure(0, hi);
      chk(hi, 2);
   endtask : t_bypass
   task automatic t_spread;
      int mx = 0, mn = 99;
      wr(8'h1C, 32'h0000_0887);
      repeat (8) @(posedge clk);
      wait_lock(n);
      repeat (40) begin
         measure(2, hi);
         if (hi > mx) mx = hi;
         if (hi < mn) mn = hi;
      end
      chk(32'(mn >= 5 && mx <= 9 && mx > 5), 32'h1);
   endtask : t_spread
   task automatic t_sleep;
      cocc_pin_model_inst.drive_sleep(1'b0, 1'b1);
      #1;
      chk({29'h0, ca, cb, cc}, 32'h0);
      repeat (8) @(posedge clk);
      chk(32'(locked), 32'h0);
   endtask : t_sleep
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_undriven();
      t_select();
      t_enable();
      t_diff();
      t_bypass();
      t_spread();
      t_sleep();
      give_verdict();
   end
   initial begin
      #(20000 * 50);
      failures++;
      give_verdict();
   end
endmodule : cocc_clock_output_config_control_bench
`default_nettype wire

// [test/cocc_pin_model.sv]
// Controller model driving select, enable, sleep pins and the reference.
// Assumes calls from the bench; undriven pins show their pull level.
`timescale 1ns/100ps
`default_nettype none
module cocc_pin_model #(
   parameter int REF_HALF = 3
) (
   input  wire logic  clk,
   output logic [1:0] sel_pin,
   output logic [1:0] sel_pin_driven,
   output logic       enable_line_a,
   output logic       enable_line_b,
   output logic       enable_line_c,
   output logic [2:0] enable_driven,
   output logic       sleep_n,
   output logic       sleep_n_driven,
   output logic       ref_input
);
   logic [2:0] en_r;
   int         cnt = 0;
   assign enable_line_a = en_r[0];
   assign enable_line_b = en_r[1];
   assign enable_line_c = en_r[2];
   initial begin
      {sel_pin, sel_pin_driven, en_r, enable_driven, sleep_n, sleep_n_driven, ref_input} = 13'h19C0;
   end
   // Free running reference
   always @(posedge clk) begin
      cnt <= (cnt == REF_HALF - 1) ? 0 : cnt + 1;
      if (cnt == REF_HALF - 1) ref_input <= ~ref_input;
   end
   task automatic drive_sel(input logic [1:0] v, input logic [1:0] d);
      @(posedge clk);
      sel_pin <= v | ~d;
      sel_pin_driven <= d;
   endtask : drive_sel
   task automatic drive_en(input logic [2:0] v, input logic [2:0] d);
      @(posedge clk);
      en_r <= v | ~d;
      enable_driven <= d;
   endtask : drive_en
   task automatic drive_sleep(input logic v, input logic d);
      @(posedge clk);
      sleep_n <= v & d;
      sleep_n_driven <= d;
   endtask : drive_sleep
endmodule : cocc_pin_model
`default_nettype wire
